// *** rtl/drvpb_pkg.sv ***
// Constants for the drive parameter bank: attribute offsets, reset values,
// bit-rate codes, state encodings and timing.
// Assumes one 25 MHz clock and attribute access by the fieldbus stack.
// What this block does
// - Bit-rate code 0/1/2 = 125/250/500 kBaud
// - Bit-rate field locked unless switch both-on
// - New bit-rate applies after a comm reset; power-on reset restores code 0
// - Signed 31-bit range end, 27200, multiturn only
// - Read-only consistency flag, singleturn only, default 1
// - Rotation sense: 0 clockwise, 1 counter-clockwise
// - Approach with 5/8 turn forward or reverse
// - Wait programmed milliseconds when reversing rotation
// - Peak torque of last run, phases excluded
// - Control supply voltage readout, 0.1 V steps
// - Motor supply voltage readout, 0.1 V steps
// - Average motor supply over 5 ms units
// - Writable temperature ceiling, default 70, retained
// - Internal temperature readout, read-only, 16 bit
package drvpb_pkg;
   // Attribute offsets
   localparam logic [7:0] ATTR_BIT_RATE  = 8'h27;
   localparam logic [7:0] ATTR_RANGE_END = 8'h28;
   localparam logic [7:0] ATTR_POS_VALID = 8'h2a;
   localparam logic [7:0] ATTR_ROT_SENSE = 8'h2c;
   localparam logic [7:0] ATTR_APPROACH  = 8'h2d;
   localparam logic [7:0] ATTR_PAUSE     = 8'h2e;
   localparam logic [7:0] ATTR_SPEED     = 8'h30;
   localparam logic [7:0] ATTR_PEAK_TRQ  = 8'h31;
   localparam logic [7:0] ATTR_TORQUE    = 8'h33;
   localparam logic [7:0] ATTR_LOGIC_V   = 8'h3a;
   localparam logic [7:0] ATTR_DRIVE_V   = 8'h3b;
   localparam logic [7:0] ATTR_DRIVE_THR = 8'h3c;
   localparam logic [7:0] ATTR_DRIVE_AVG = 8'h3d;
   localparam logic [7:0] ATTR_HEAT_CEIL = 8'h3e;
   localparam logic [7:0] ATTR_HEAT_NOW  = 8'h3f;

   // Values after reset
   localparam logic [7:0]  RST_BIT_RATE  = 8'h00;
   localparam logic [31:0] RST_RANGE_END = 32'h0000_6a40;
   localparam logic [7:0]  RST_POS_VALID = 8'h01;
   localparam logic [7:0]  RST_ROT_SENSE = 8'h00;
   localparam logic [7:0]  RST_APPROACH  = 8'h00;
   localparam logic [15:0] RST_PAUSE     = 16'h000a;
   localparam logic [15:0] RST_DRIVE_THR = 16'h00b9;
   localparam logic [15:0] RST_DRIVE_AVG = 16'h0064;
   localparam logic [15:0] RST_HEAT_CEIL = 16'h0046;

   // Bit-rate codes
   localparam logic [1:0] BAUD_125K = 2'h0;
   localparam logic [1:0] BAUD_250K = 2'h1;
   localparam logic [1:0] BAUD_500K = 2'h2;
   localparam logic [7:0] BAUD_MAX  = 8'h02;

   // Timing
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int MS_TICK_US      = 1000;
   localparam int MS_TICK_CYCLES  = MS_TICK_US * 1000 / CLOCK_PERIOD_NS;
   localparam int AVG_TICK_MS     = 5;
   localparam int AVG_TICK_CYCLES = AVG_TICK_MS * MS_TICK_CYCLES;
   localparam int DIV_STEPS       = 32;

   // Reversal pause states
   typedef enum logic [1:0] {
      DRVPB_PAUSE_IDLE = 2'b01,
      DRVPB_PAUSE_WAIT = 2'b10
   } drvpb_pause_t;

   // Averager states
   typedef enum logic [1:0] {
      DRVPB_AVG_ACC = 2'b01,
      DRVPB_AVG_DIV = 2'b10
   } drvpb_avg_t;
endpackage

// *** rtl/drvpb_average.sv ***
// Windowed mean of the motor supply reading with a serial divider.
// Assumes tick is a one-cycle pulse every 5 ms on the same clock.
`timescale 1ns/1ps
module drvpb_average (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        tick,
   input  wire logic [15:0] window,
   input  wire logic [15:0] sample,
   output logic      [15:0] mean,
   output logic             mean_strobe
);
   import drvpb_pkg::*;

   drvpb_avg_t  state;
   drvpb_avg_t  next_state;
   logic [31:0] sum;
   logic [31:0] next_sum;
   logic [15:0] count;
   logic [15:0] next_count;
   logic [15:0] divisor;
   logic [15:0] next_divisor;
   logic [31:0] quot;
   logic [31:0] next_quot;
   logic [16:0] rem;
   logic [16:0] next_rem;
   logic [5:0]  steps;
   logic [5:0]  next_steps;
   logic [15:0] next_mean;
   logic        next_mean_strobe;
   logic [15:0] win_eff;
   logic [16:0] rem_shift;

   // A zero window would divide by zero, so it acts as one sample
   assign win_eff   = (window == 16'h0000) ? 16'h0001 : window;
   assign rem_shift = {rem[15:0], quot[31]};

   // Accumulate one sample per 5 ms unit, then divide by the window
   always_comb begin
      next_state       = state;
      next_sum         = sum;
      next_count       = count;
      next_divisor     = divisor;
      next_quot        = quot;
      next_rem         = rem;
      next_steps       = steps;
      next_mean        = mean;
      next_mean_strobe = 1'b0;
      case (state)
         DRVPB_AVG_ACC: begin
            if (tick) begin
               if (count + 16'h0001 >= win_eff) begin
                  next_quot    = sum + {16'h0000, sample};
                  next_divisor = win_eff;
                  next_rem     = 17'h00000;
                  next_steps   = 6'h00;
                  next_sum     = 32'h0000_0000;
                  next_count   = 16'h0000;
                  next_state   = DRVPB_AVG_DIV;
               end else begin
                  next_sum   = sum + {16'h0000, sample};
                  next_count = count + 16'h0001;
               end
            end
         end
         DRVPB_AVG_DIV: begin
            // Restoring division, one quotient bit per cycle
            if (rem_shift >= {1'b0, divisor}) begin
               next_rem  = rem_shift - {1'b0, divisor};
               next_quot = {quot[30:0], 1'b1};
            end else begin
               next_rem  = rem_shift;
               next_quot = {quot[30:0], 1'b0};
            end
            next_steps = steps + 6'h01;
            if (steps == 6'(DIV_STEPS - 1)) begin
               next_mean        = next_quot[15:0];
               next_mean_strobe = 1'b1;
               next_state       = DRVPB_AVG_ACC;
            end
         end
         default: next_state = DRVPB_AVG_ACC;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state       <= DRVPB_AVG_ACC;
         sum         <= 32'h0000_0000;
         count       <= 16'h0000;
         divisor     <= 16'h0001;
         quot        <= 32'h0000_0000;
         rem         <= 17'h00000;
         steps       <= 6'h00;
         mean        <= 16'h0000;
         mean_strobe <= 1'b0;
      end else begin
         state       <= next_state;
         sum         <= next_sum;
         count       <= next_count;
         divisor     <= next_divisor;
         quot        <= next_quot;
         rem         <= next_rem;
         steps       <= next_steps;
         mean        <= next_mean;
         mean_strobe <= next_mean_strobe;
      end
   end
endmodule

// *** rtl/drvpb_bank.sv ***
// Parameter and measurement bank of a positioning drive, reached by
// attribute number from the fieldbus stack.
// Assumes measurement and motion inputs come from logic on this clock;
// only the bit-rate switch is an asynchronous pin.
`timescale 1ns/1ps
module drvpb_bank #(
   parameter bit MULTITURN       = 1'b1,
   parameter int MS_CYCLES       = drvpb_pkg::MS_TICK_CYCLES,
   parameter int AVG_UNIT_CYCLES = drvpb_pkg::AVG_TICK_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        comm_reset,
   input  wire logic [7:0]  attr_addr,
   input  wire logic        attr_write,
   input  wire logic        attr_read,
   input  wire logic [31:0] attr_wdata,
   output logic      [31:0] attr_rdata,
   output logic             attr_ack,
   output logic             attr_error,
   input  wire logic        baud_switch_on_on,
   output logic      [1:0]  baud_code,
   output logic             baud_code_valid,
   output logic      [31:0] range_end,
   output logic             ccw_sense,
   output logic             approach_reverse,
   input  wire logic        reversal_request,
   output logic             reversal_hold,
   input  wire logic        run_active,
   input  wire logic        start_phase,
   input  wire logic        braking,
   input  wire logic        position_consistent_in,
   input  wire logic [15:0] speed_in,
   input  wire logic [15:0] torque_in,
   input  wire logic [15:0] logic_volts_in,
   input  wire logic [15:0] drive_volts_in,
   input  wire logic [15:0] heat_in,
   output logic      [15:0] drive_volts_mean,
   output logic             drive_supply_low,
   output logic             heat_over
);
   import drvpb_pkg::*;

   logic [7:0]  bit_rate_select, next_bit_rate_select;
   logic [31:0] range_upper_end, next_range_upper_end;
   logic [7:0]  position_valid_flag, next_position_valid_flag;
   logic [7:0]  rotation_sense, next_rotation_sense;
   logic [7:0]  approach_side, next_approach_side;
   logic [15:0] reversal_pause_ms, next_reversal_pause_ms;
   logic [15:0] speed_now, torque_now, logic_supply_volts;
   logic [15:0] drive_supply_volts, internal_heat_reading;
   logic [15:0] peak_run_torque, next_peak_run_torque;
   logic [15:0] drive_supply_threshold, next_drive_supply_threshold;
   logic [15:0] drive_supply_averaging, next_drive_supply_averaging;
   logic [15:0] heat_ceiling, next_heat_ceiling;
   logic [1:0]  next_baud_code;
   logic [31:0] next_attr_rdata;
   logic        next_attr_ack, next_attr_error;
   logic        sw_meta, sw_mid, sw_late, sw_level, next_sw_level;
   logic        run_seen;
   logic        hit, is_ro, wr_ok;
   logic [31:0] rd_mux;
   drvpb_pause_t pause_state, next_pause_state;
   logic [15:0] pause_left, next_pause_left;
   logic [31:0] pause_cyc, next_pause_cyc;
   logic [31:0] avg_cyc, next_avg_cyc;
   logic        avg_tick;
   logic        next_supply_low, next_heat_over;

   // Decode and read mux; absent variant entries read as zero
   always_comb begin
      hit    = 1'b1;
      is_ro  = 1'b0;
      rd_mux = 32'h0000_0000;
      case (attr_addr)
         ATTR_BIT_RATE:  rd_mux = {24'h000000, bit_rate_select};
         ATTR_RANGE_END: rd_mux = MULTITURN ? range_upper_end : 32'h0000_0000;
         ATTR_POS_VALID: begin
            is_ro  = 1'b1;
            rd_mux = MULTITURN ? 32'h0000_0000 : {24'h000000, position_valid_flag};
         end
         ATTR_ROT_SENSE: rd_mux = {24'h000000, rotation_sense};
         ATTR_APPROACH:  rd_mux = {24'h000000, approach_side};
         ATTR_PAUSE:     rd_mux = {16'h0000, reversal_pause_ms};
         ATTR_SPEED:     begin is_ro = 1'b1; rd_mux = {16'h0000, speed_now}; end
         ATTR_PEAK_TRQ:  begin is_ro = 1'b1; rd_mux = {16'h0000, peak_run_torque}; end
         ATTR_TORQUE:    begin is_ro = 1'b1; rd_mux = {16'h0000, torque_now}; end
         ATTR_LOGIC_V:   begin is_ro = 1'b1; rd_mux = {16'h0000, logic_supply_volts}; end
         ATTR_DRIVE_V:   begin is_ro = 1'b1; rd_mux = {16'h0000, drive_supply_volts}; end
         ATTR_DRIVE_THR: rd_mux = {16'h0000, drive_supply_threshold};
         ATTR_DRIVE_AVG: rd_mux = {16'h0000, drive_supply_averaging};
         ATTR_HEAT_CEIL: rd_mux = {16'h0000, heat_ceiling};
         ATTR_HEAT_NOW:  begin is_ro = 1'b1; rd_mux = {16'h0000, internal_heat_reading}; end
         default:        hit = 1'b0;
      endcase
   end

   assign wr_ok = attr_write && hit && !is_ro;

   // Writable entries and the answer to each access
   always_comb begin
      next_bit_rate_select        = bit_rate_select;
      next_range_upper_end        = range_upper_end;
      next_rotation_sense         = rotation_sense;
      next_approach_side          = approach_side;
      next_reversal_pause_ms      = reversal_pause_ms;
      next_drive_supply_threshold = drive_supply_threshold;
      next_drive_supply_averaging = drive_supply_averaging;
      next_heat_ceiling           = heat_ceiling;
      next_attr_ack               = attr_write || attr_read;
      next_attr_error             = (attr_write || attr_read) && !hit;
      next_attr_rdata             = attr_read ? rd_mux : attr_rdata;
      if (attr_write && is_ro) begin
         next_attr_error = 1'b1;
      end
      if (wr_ok) begin
         case (attr_addr)
            ATTR_BIT_RATE: begin
               // Switch not both-on or code out of range leaves it alone
               if (!sw_level || attr_wdata[7:0] > BAUD_MAX) begin
                  next_attr_error = 1'b1;
               end else begin
                  next_bit_rate_select = attr_wdata[7:0];
               end
            end
            ATTR_RANGE_END: begin
               // Sign taken from bit 30; master keeps the value in span
               if (MULTITURN) begin
                  next_range_upper_end = {attr_wdata[30], attr_wdata[30:0]};
               end else begin
                  next_attr_error = 1'b1;
               end
            end
            ATTR_ROT_SENSE: next_rotation_sense         = {7'h00, attr_wdata[0]};
            ATTR_APPROACH:  next_approach_side          = {7'h00, attr_wdata[0]};
            ATTR_PAUSE:     next_reversal_pause_ms      = attr_wdata[15:0];
            ATTR_DRIVE_THR: next_drive_supply_threshold = attr_wdata[15:0];
            ATTR_DRIVE_AVG: next_drive_supply_averaging = attr_wdata[15:0];
            ATTR_HEAT_CEIL: next_heat_ceiling           = attr_wdata[15:0];
            default:        next_attr_error             = 1'b1;
         endcase
      end
   end

   // Switch level accepted once the last two sync stages agree
   always_comb begin
      next_sw_level = (sw_mid == sw_late) ? sw_late : sw_level;
   end

   // Bit rate latched only at a reset, never on the write itself
   always_comb begin
      next_baud_code = baud_code;
      if (comm_reset) begin
         next_baud_code = bit_rate_select[1:0];
      end
   end

   // Peak torque restarts with each run; start and braking phases skipped
   always_comb begin
      next_peak_run_torque = peak_run_torque;
      if (run_active && !run_seen) begin
         next_peak_run_torque = 16'h0000;
      end else if (run_active && !start_phase && !braking &&
                   torque_in > peak_run_torque) begin
         next_peak_run_torque = torque_in;
      end
      next_position_valid_flag = {7'h00, position_consistent_in};
   end

   // Reversal pause: own prescaler so the first millisecond is whole
   always_comb begin
      next_pause_state = pause_state;
      next_pause_left  = pause_left;
      next_pause_cyc   = pause_cyc;
      case (pause_state)
         DRVPB_PAUSE_IDLE: begin
            if (reversal_request && reversal_pause_ms != 16'h0000) begin
               next_pause_left  = reversal_pause_ms;
               next_pause_cyc   = 32'h0000_0000;
               next_pause_state = DRVPB_PAUSE_WAIT;
            end
         end
         DRVPB_PAUSE_WAIT: begin
            if (pause_cyc == 32'(MS_CYCLES - 1)) begin
               next_pause_cyc  = 32'h0000_0000;
               next_pause_left = pause_left - 16'h0001;
               if (pause_left == 16'h0001) begin
                  next_pause_state = DRVPB_PAUSE_IDLE;
               end
            end else begin
               next_pause_cyc = pause_cyc + 32'h0000_0001;
            end
         end
         default: next_pause_state = DRVPB_PAUSE_IDLE;
      endcase
   end

   // 5 ms unit divider feeding the averager, and the limit comparisons
   always_comb begin
      avg_tick     = (avg_cyc == 32'(AVG_UNIT_CYCLES - 1));
      next_avg_cyc = avg_tick ? 32'h0000_0000 : avg_cyc + 32'h0000_0001;
      next_supply_low = drive_volts_mean < drive_supply_threshold;
      next_heat_over  = internal_heat_reading > heat_ceiling;
   end

   // Registers; heat_ceiling holds across comm resets, only power-on reloads
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bit_rate_select        <= RST_BIT_RATE;
         range_upper_end        <= RST_RANGE_END;
         position_valid_flag    <= RST_POS_VALID;
         rotation_sense         <= RST_ROT_SENSE;
         approach_side          <= RST_APPROACH;
         reversal_pause_ms      <= RST_PAUSE;
         drive_supply_threshold <= RST_DRIVE_THR;
         drive_supply_averaging <= RST_DRIVE_AVG;
         heat_ceiling           <= RST_HEAT_CEIL;
         baud_code              <= RST_BIT_RATE[1:0];
         attr_rdata             <= 32'h0000_0000;
         attr_ack               <= 1'b0;
         attr_error             <= 1'b0;
         sw_meta                <= 1'b0;
         sw_mid                 <= 1'b0;
         sw_late                <= 1'b0;
         sw_level               <= 1'b0;
         run_seen               <= 1'b0;
         peak_run_torque        <= 16'h0000;
         speed_now              <= 16'h0000;
         torque_now             <= 16'h0000;
         logic_supply_volts     <= 16'h0000;
         drive_supply_volts     <= 16'h0000;
         internal_heat_reading  <= 16'h0000;
         pause_state            <= DRVPB_PAUSE_IDLE;
         pause_left             <= 16'h0000;
         pause_cyc              <= 32'h0000_0000;
         avg_cyc                <= 32'h0000_0000;
         drive_supply_low       <= 1'b0;
         heat_over              <= 1'b0;
      end else begin
         bit_rate_select        <= next_bit_rate_select;
         range_upper_end        <= next_range_upper_end;
         position_valid_flag    <= next_position_valid_flag;
         rotation_sense         <= next_rotation_sense;
         approach_side          <= next_approach_side;
         reversal_pause_ms      <= next_reversal_pause_ms;
         drive_supply_threshold <= next_drive_supply_threshold;
         drive_supply_averaging <= next_drive_supply_averaging;
         heat_ceiling           <= next_heat_ceiling;
         baud_code              <= next_baud_code;
         attr_rdata             <= next_attr_rdata;
         attr_ack               <= next_attr_ack;
         attr_error             <= next_attr_error;
         sw_meta                <= baud_switch_on_on;
         sw_mid                 <= sw_meta;
         sw_late                <= sw_mid;
         sw_level               <= next_sw_level;
         run_seen               <= run_active;
         peak_run_torque        <= next_peak_run_torque;
         speed_now              <= speed_in;
         torque_now             <= torque_in;
         logic_supply_volts     <= logic_volts_in;
         drive_supply_volts     <= drive_volts_in;
         internal_heat_reading  <= heat_in;
         pause_state            <= next_pause_state;
         pause_left             <= next_pause_left;
         pause_cyc              <= next_pause_cyc;
         avg_cyc                <= next_avg_cyc;
         drive_supply_low       <= next_supply_low;
         heat_over              <= next_heat_over;
      end
   end

   // Decoded settings for the motion logic
   assign baud_code_valid  = (baud_code <= BAUD_500K);
   assign range_end        = MULTITURN ? range_upper_end : 32'h0000_0000;
   assign ccw_sense        = rotation_sense[0];
   assign approach_reverse = approach_side[0];
   assign reversal_hold    = (pause_state == DRVPB_PAUSE_WAIT);

   drvpb_average u_average (
      .clock       (clock),
      .reset       (reset),
      .tick        (avg_tick),
      .window      (drive_supply_averaging),
      .sample      (drive_supply_volts),
      .mean        (drive_volts_mean),
      .mean_strobe ()
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   chk_baud_decode: assert property (baud_code_valid == (baud_code != 2'h3))
      else $error("bit-rate validity wrong");
   chk_baud_lock: assert property (attr_write && attr_addr == ATTR_BIT_RATE && !sw_level
      |=> $stable(bit_rate_select))
      else $error("bit-rate changed while locked");
   chk_baud_defer: assert property (!$past(comm_reset) |-> $stable(baud_code))
      else $error("bit-rate applied without reset");
   chk_range_write: assert property (MULTITURN && wr_ok && attr_addr == ATTR_RANGE_END
      |=> range_end[30:0] == $past(attr_wdata[30:0]))
      else $error("range end not stored");
   chk_flag_variant: assert property (attr_read && attr_addr == ATTR_POS_VALID
      |=> attr_rdata == (MULTITURN ? 32'h0 : {31'h0, $past(position_valid_flag[0])}))
      else $error("consistency flag read wrong");
   chk_sense_out: assert property (wr_ok && attr_addr == ATTR_ROT_SENSE
      |=> ##1 ccw_sense == $past(attr_wdata[0], 2))
      else $error("rotation sense not applied");
   chk_pause_start: assert property (!reversal_hold && reversal_request
      && reversal_pause_ms != 16'h0 |=> reversal_hold [*8])
      else $error("reversal pause missing");
   chk_peak_hold: assert property (run_active && $past(run_active) && (start_phase || braking)
      |=> $stable(peak_run_torque))
      else $error("peak moved in excluded phase");
   chk_ro_ignore: assert property (attr_write && is_ro |=> attr_error)
      else $error("read-only write not refused");
   chk_heat_keep: assert property (comm_reset && !wr_ok |=> $stable(heat_ceiling))
      else $error("temperature ceiling lost");
endmodule

// *** bench/drvpb_master.sv ***
// Fieldbus master model: one attribute access per call.
// Assumes the bank acknowledges one cycle after the strobe edge.
`timescale 1ns/1ps
module drvpb_master (
   input  wire logic        clock,
   output logic      [7:0]  attr_addr,
   output logic             attr_write,
   output logic             attr_read,
   output logic      [31:0] attr_wdata
);
   initial begin
      attr_addr = 8'h00;
      attr_write = 1'b0;
      attr_read = 1'b0;
      attr_wdata = 32'h0;
   end
   // Strobe for one edge, then release; stale data is inverted, not held
   task automatic access(input bit wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      attr_addr <= a;
      attr_wdata <= d;
      attr_write <= wr;
      attr_read <= !wr;
      @(posedge clock);
      attr_write <= 1'b0;
      attr_read <= 1'b0;
      attr_wdata <= ~d;
   endtask
endmodule

// *** bench/drvpb_bank_tb_top.sv ***
// Self-checking bench for the drive parameter bank.
// Assumes the master model drives the attribute port; timing counts shortened.
`timescale 1ns/1ps
module drvpb_bank_tb_top;
   import drvpb_pkg::*;
   logic        clock = 1'b0, reset = 1'b1, comm_reset = 1'b0, sw = 1'b0, rev_req = 1'b0;
   logic        run = 1'b0, start_ph = 1'b0, brake = 1'b0, pos_ok = 1'b1;
   logic [15:0] spd, trq, lv, dv, heat;
   logic [7:0]  attr_addr;
   logic        attr_write, attr_read, attr_ack, attr_error, ccw, appr, hold;
   logic [31:0] attr_wdata, attr_rdata;
   logic [1:0]  baud_code;
   logic [31:0] rend;
   logic [15:0] mean;
   logic        valid, low, hot;
   logic [33:0] exp_q[$];
   logic [7:0]  rst_a[9] = '{8'h27, 8'h28, 8'h2a, 8'h2c, 8'h2d, 8'h2e, 8'h3c, 8'h3d, 8'h3e};
   logic [31:0] rst_v[9] = '{32'h0, 32'h6a40, 32'h0, 32'h0, 32'h0, 32'ha, 32'hb9, 32'h64, 32'h46};
   logic [7:0]  ro_a[5] = '{8'h30, 8'h33, 8'h3a, 8'h3b, 8'h3f};
   logic [31:0] ro_v[5];
   logic [18:0] ph[4] = '{{3'b110, 16'h0320}, {3'b100, 16'h012c}, {3'b101, 16'h0384}, 19'h0064};
   int          miscompares = 0, cmp_count = 0, seed = 32'h6fd6, n, k;

   always #20 clock = ~clock;

   drvpb_master m_u (.clock(clock), .attr_addr(attr_addr), .attr_write(attr_write),
      .attr_read(attr_read), .attr_wdata(attr_wdata));

   drvpb_bank #(.MS_CYCLES(10), .AVG_UNIT_CYCLES(20)) dut_u (.clock(clock), .reset(reset),
      .comm_reset(comm_reset), .attr_addr(attr_addr), .attr_write(attr_write),
      .attr_read(attr_read), .attr_wdata(attr_wdata), .attr_rdata(attr_rdata),
      .attr_ack(attr_ack), .attr_error(attr_error), .baud_switch_on_on(sw),
      .baud_code(baud_code), .baud_code_valid(valid), .range_end(rend), .ccw_sense(ccw),
      .approach_reverse(appr), .reversal_request(rev_req), .reversal_hold(hold),
      .run_active(run), .start_phase(start_ph), .braking(brake),
      .position_consistent_in(pos_ok), .speed_in(spd), .torque_in(trq),
      .logic_volts_in(lv), .drive_volts_in(dv), .heat_in(heat), .drive_volts_mean(mean),
      .drive_supply_low(low), .heat_over(hot));

   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Note {is_read, error, data}, then issue; reads carry expected data
   task automatic acc(input bit wr, input logic [7:0] a, input logic [31:0] d, input bit err);
      exp_q.push_back({!wr, err, d});
      m_u.access(wr, a, d);
   endtask

   // Each acknowledge retires the oldest note; checked mid-cycle when settled
   always @(negedge clock) begin
      if (attr_ack === 1'b1 && exp_q.size() > 0) begin
         check("attr_error", 32'(attr_error), 32'(exp_q[0][32]));
         if (exp_q[0][33]) check("attr_rdata", attr_rdata, exp_q[0][31:0]);
         void'(exp_q.pop_front());
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      report_and_stop;
   end

   initial begin
      {spd, trq, lv, dv, heat} <= 80'({$random(seed), $random(seed), $random(seed)});
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      foreach (rst_a[i]) acc(0, rst_a[i], rst_v[i], 0);
      ro_v = '{spd, trq, lv, dv, heat};
      foreach (ro_a[i]) begin
         acc(1, ro_a[i], 32'h5, 1);
         acc(0, ro_a[i], ro_v[i], 0);
      end
      acc(1, 8'h29, 32'h5, 1);
      acc(1, 8'h27, 32'h1, 1);
      acc(0, 8'h27, 32'h0, 0); // Locked write left no trace
      sw <= 1'b1;
      repeat (5) @(posedge clock);
      for (n = 0; n < 4; n++) acc(1, 8'h27, n, n > 2);
      acc(0, 8'h27, 32'h2, 0);
      acc(1, 8'h3e, 32'h3c, 0);
      check("baud_code", 32'(baud_code), 32'h0);
      comm_reset <= 1'b1;
      @(posedge clock);
      comm_reset <= 1'b0;
      @(negedge clock);
      check("baud_code", 32'(baud_code), 32'h2);
      check("baud_code_valid", 32'(valid), 32'h1);
      acc(0, 8'h3e, 32'h3c, 0); // Ceiling survives the comm reset
      acc(1, 8'h2c, 32'h1, 0);
      acc(1, 8'h2d, 32'h1, 0);
      @(negedge clock);
      check("ccw_sense", 32'(ccw), 32'h1);
      check("approach_reverse", 32'(appr), 32'h1);
      acc(1, 8'h28, 32'h1234, 0); // Inside the master's allowed span
      acc(0, 8'h28, 32'h1234, 0);
      check("range_end", rend, 32'h1234);
      n = {$random(seed)} % 3 + 1;
      acc(1, 8'h2e, n, 0);
      rev_req <= 1'b1;
      @(posedge clock);
      rev_req <= 1'b0;
      @(negedge clock);
      for (k = 0; k < 200 && hold === 1'b1; k++) @(negedge clock);
      check("reversal_hold", k, n * 10);
      // Start-phase and braking peaks must not count
      for (n = 0; n < 4; n++) begin
         @(posedge clock);
         {run, start_ph, brake, trq} <= ph[n];
         repeat (3) @(posedge clock);
      end
      acc(0, 8'h31, 32'h12c, 0);
      for (n = 0; n < 10 && exp_q.size() > 0; n++) @(posedge clock);
      // An answer that never came is a mismatch too
      if (exp_q.size() > 0) miscompares++;
      // Constant motor supply, so the window mean must equal the sample
      for (k = 0; k < 3000 && mean !== dv; k++) @(negedge clock);
      check("drive_volts_mean", 32'(mean), 32'(dv));
      @(negedge clock);
      check("drive_supply_low", 32'(low), 32'(dv < 16'h00b9));
      check("heat_over", 32'(hot), 32'(heat > 16'h003c));
      report_and_stop;
   end
endmodule
